// >>> hw/phy_media_pkg.sv
// shared constants and carriers for the media interface block
// assumes a 10 MHz ref_clk and an APB master with 32-bit data
package phy_media_pkg;

  // operating modes; the register field holds the enum order
  typedef enum logic [1:0] {MODE_GMII, MODE_MII, MODE_TBI} link_mode_e;

  // received pin bundle; in TBI the whole bundle is one code group
  typedef struct packed {
    logic       er;     // receive error, or group bit 9
    logic       dv;     // receive data valid, or group bit 8
    logic [7:0] data;   // receive data, or group bits 7..0
  } rx_pins_s;

  // transmitted pin bundle
  typedef struct packed {
    logic       en;     // transmit enable, or group bit 9
    logic       b8;     // group bit 8, TBI only
    logic       er;     // transmit error
    logic [7:0] data;   // transmit data, or group bits 7..0
  } tx_pins_s;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TXDATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;
  localparam logic [7:0] ADDR_CLEAR  = 8'h10;

  // control field positions
  localparam int CTRL_MODE_LSB = 0;   // two bits
  localparam int CTRL_FULL_DUP = 2;
  localparam int CTRL_LOOPBACK = 3;
  localparam int CTRL_PWR_DOWN = 4;
  localparam int CTRL_LED_LSB  = 5;   // two bits
  localparam int CTRL_LINK_UP  = 7;
  localparam int CTRL_SPD_LSB  = 8;   // two bits: 0=10M 1=100M 2=1000M
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // transmit data word fields
  localparam int TXW_LAST = 10;
  localparam int TXW_ERR  = 11;

  // receive data word fields
  localparam int RXW_END  = 10;
  localparam int RXW_ODD  = 11;

  // status / clear bit positions
  localparam int ST_TX_FREE  = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_CODE_ERR = 2;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_COL_SEEN = 4;
  localparam int ST_CRS      = 5;
  localparam int ST_TX_ACT   = 6;
  localparam int ST_COL_NOW  = 7;

  // speed codes
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // gigabit transmit clock: nominal rate and the divider built from ref_clk
  localparam int REF_CLK_HZ      = 10_000_000;
  localparam int GTX_NOMINAL_HZ  = 125_000_000;
  localparam int GTX_HALF_CYCLES = (REF_CLK_HZ / (2 * GTX_NOMINAL_HZ) < 1) ? 1
                                   : REF_CLK_HZ / (2 * GTX_NOMINAL_HZ);
  localparam logic [3:0] GTX_HALF_LAST = 4'(GTX_HALF_CYCLES - 1);

  // synchroniser width: tx clk, odd clk, even clk, col, crs, rx bundle
  localparam int SYNC_W = 15;

endpackage

// >>> hw/sync_bits.sv
// two-flop synchroniser for a bundle of asynchronous inputs
// assumes every bit is independent or sampled again downstream
`timescale 1ns/10ps
module sync_bits #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_syncOut;

  // first stage feeds only the second stage
  always_comb begin
    next_meta    = asyncIn;
    next_syncOut = meta;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta    <= '0;
      syncOut <= '0;
    end else begin
      meta    <= next_meta;
      syncOut <= next_syncOut;
    end
  end

endmodule

// >>> hw/link_indicator.sv
// indicator selection for the four active-low link lamps
// assumes condition inputs are already on ref_clk
`timescale 1ns/10ps
module link_indicator
  import phy_media_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       tbiMode,
  input  wire logic [1:0] selectCode,
  input  wire logic       powerDown,
  input  wire logic       linkUp,
  input  wire logic [1:0] speed,
  input  wire logic       fullDuplex,
  input  wire logic       txAct,
  input  wire logic       rxAct,
  output logic      [3:0] linkIndicatorN
);

  logic [3:0] lampOn;
  logic [3:0] next_linkIndicatorN;
  logic       act;
  logic       l10;
  logic       l100;
  logic       l1000;

  // per-code lamp table, separate for copper and TBI
  always_comb begin
    act   = txAct | rxAct;
    l10   = linkUp & (speed == SPEED_10);
    l100  = linkUp & (speed == SPEED_100);
    l1000 = linkUp & (speed == SPEED_1000);
    lampOn = 4'h0;
    if (!tbiMode) begin
      case (selectCode)
        2'h0:    lampOn = {l1000, l10, l100, act};
        2'h1:    lampOn = {1'b0, fullDuplex, linkUp, act};
        2'h2:    lampOn = {fullDuplex, rxAct, linkUp, txAct};
        // combined link/activity lamps go dark while traffic flows
        2'h3:    lampOn = {l1000 & ~act, fullDuplex, l100 & ~act, l10 & ~act};
        default: lampOn = 4'h0;
      endcase
    end else begin
      case (selectCode)
        2'h0:    lampOn = {linkUp, 1'b0, 1'b0, act};
        2'h1:    lampOn = {1'b0, fullDuplex, linkUp, act};
        2'h2:    lampOn = {fullDuplex, rxAct, linkUp, txAct};
        2'h3:    lampOn = {linkUp, fullDuplex, 1'b0, 1'b0};
        default: lampOn = 4'h0;
      endcase
    end
    next_linkIndicatorN = powerDown ? 4'hf : ~lampOn;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      linkIndicatorN <= 4'hf;
    end else begin
      linkIndicatorN <= next_linkIndicatorN;
    end
  end

endmodule

// >>> hw/phy_media_interface.sv
// MAC-side media interface: GMII, MII and TBI transmit/receive, lamps
// assumes PHY clocks are far slower than ref_clk so edges can be sampled
//
// Function
// - GMII drives continuous gigabit transmit clock; gtxClk here toggles every ref_clk cycle, 5 MHz rather than 125 MHz
// - TBI uses same transmit clock as reference
// - transmit enable spans exactly the frame
// - GMII full byte, MII low nibble
// - transmit data changes on its clock
// - TBI sends ten-bit group across pins
// - receive pins sampled at receive clock rise
// - frame data taken only while valid
// - GMII byte receive, MII low nibble
// - receive error flags coding error
// - odd groups latched on first clock
// - even groups latched on second clock
// - group bit 0 earliest, bit 9 last
// - collision ignored in full duplex
// - collision input synchronised before use
// - collision ignored in TBI mode
// - four active-low lamps, selectable meanings
// - carrier sense synchronised, ignored in TBI
// - loopback output high in TBI loopback
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module phy_media_interface
  import phy_media_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        txClkIn,
  input  wire logic        oddGroupRxClock,
  input  wire logic        evenGroupRxClock,
  input  wire rx_pins_s    rxPins,
  input  wire logic        collisionIn,
  input  wire logic        carrierSenseIn,
  output logic             gtxClk,
  output tx_pins_s         txPins,
  output logic      [3:0]  linkIndicatorN,
  output logic             tenbitLoopbackFlagOut
);

  // synchronised pins and edge history
  logic [SYNC_W-1:0] syncVec;
  logic              txClkS, oddClkS, evenClkS, colS, crsS;
  rx_pins_s          rxS, rxPrev;
  logic [2:0]        clkPrev;
  logic              txClkRise, oddRise, evenRise;

  // register state
  logic [9:0]        ctrl, next_ctrl;
  logic [31:0]       next_prdata;
  logic              next_pready, next_pslverr, next_loop, fullDuplex;
  link_mode_e        mode;
  logic              wrTake, rdTake, wrTx, wrClr, rdRx, addrOk;

  // transmit state
  logic [3:0]        gtxCnt, next_gtxCnt, txHiNib, next_txHiNib;
  logic [11:0]       txHold, next_txHold;
  logic              next_gtxClk, gtxFall, txTick, txHoldValid, next_txHoldValid;
  logic              txActive, next_txActive, nibbleHi, next_nibbleHi, txLastPend, next_txLastPend;
  tx_pins_s          next_txPins;

  // receive state
  logic [11:0]       rxWord, next_rxWord, pushWord;
  logic [3:0]        rxLow, next_rxLow;
  logic              rxValid, next_rxValid, rxHalf, next_rxHalf, rxInFrame, next_rxInFrame;
  logic              codeErr, next_codeErr, overrun, next_overrun, colSeen, next_colSeen;
  logic              colEff, crsEff, pushRx;

  // all pins from the PHY cross here before anything reads them
  sync_bits #(.WIDTH(SYNC_W)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .asyncIn ({txClkIn, oddGroupRxClock, evenGroupRxClock, collisionIn, carrierSenseIn, rxPins}),
    .syncOut (syncVec)
  );

  // unpack synchronised bundle and find clock rises
  always_comb begin
    {txClkS, oddClkS, evenClkS, colS, crsS, rxS} = syncVec;
    txClkRise  = txClkS & ~clkPrev[2];
    oddRise    = oddClkS & ~clkPrev[1];
    evenRise   = evenClkS & ~clkPrev[0];
    mode       = (ctrl[CTRL_MODE_LSB +: 2] == 2'h1) ? MODE_MII
               : (ctrl[CTRL_MODE_LSB +: 2] == 2'h2) ? MODE_TBI : MODE_GMII;
    fullDuplex = ctrl[CTRL_FULL_DUP];
    colEff     = colS & ~fullDuplex & (mode != MODE_TBI);
    crsEff     = crsS & (mode != MODE_TBI);
  end

  // history registers; rxPrev holds data sampled before the clock rose,
  // so a pin that changes with the rise is not caught mid-transition
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clkPrev <= 3'h0;
      rxPrev  <= '0;
    end else begin
      clkPrev <= {txClkS, oddClkS, evenClkS};
      rxPrev  <= rxS;
    end
  end

  // APB slave: zero wait states, pready answers in the first access cycle
  always_comb begin
    addrOk       = (paddr == ADDR_CTRL) | (paddr == ADDR_TXDATA) | (paddr == ADDR_STATUS)
                 | (paddr == ADDR_RXDATA) | (paddr == ADDR_CLEAR);
    wrTake       = psel & penable & pready & pwrite;
    rdTake       = psel & penable & pready & ~pwrite;
    wrTx         = wrTake & (paddr == ADDR_TXDATA);
    wrClr        = wrTake & (paddr == ADDR_CLEAR);
    rdRx         = rdTake & (paddr == ADDR_RXDATA);
    next_ctrl    = (wrTake & (paddr == ADDR_CTRL)) ? pwdata[9:0] : ctrl;
    next_pready  = psel & ~penable;
    next_pslverr = psel & ~penable & ~addrOk;
    next_prdata  = 32'h0;
    if (psel & ~penable & ~pwrite) begin
      case (paddr)
        ADDR_CTRL:   next_prdata = {22'h0, ctrl};
        ADDR_STATUS: next_prdata = {24'h0, colEff, txActive, crsEff, colSeen,
                                    overrun, codeErr, rxValid, ~txHoldValid};
        ADDR_RXDATA: next_prdata = {20'h0, rxWord};
        default:     next_prdata = 32'h0;
      endcase
    end
    next_loop = ctrl[CTRL_LOOPBACK] & (mode == MODE_TBI);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl                  <= CTRL_RESET;
      prdata                <= 32'h0;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      tenbitLoopbackFlagOut <= 1'b0;
    end else begin
      ctrl                  <= next_ctrl;
      prdata                <= next_prdata;
      pready                <= next_pready;
      pslverr               <= next_pslverr;
      tenbitLoopbackFlagOut <= next_loop;
    end
  end

  // transmit: gigabit clock divider, one-word holding register, pin driver
  always_comb begin
    next_gtxCnt      = (gtxCnt == GTX_HALF_LAST) ? 4'h0 : gtxCnt + 4'h1;
    next_gtxClk      = (gtxCnt == GTX_HALF_LAST) ? ~gtxClk : gtxClk;
    // data moves on the falling edge so the PHY sees it stable at the rise
    gtxFall          = (gtxCnt == GTX_HALF_LAST) & gtxClk;
    txTick           = (mode == MODE_MII) ? txClkRise : gtxFall;
    next_txHold      = txHold;
    next_txHoldValid = txHoldValid;
    next_txActive    = txActive;
    next_nibbleHi    = nibbleHi;
    next_txHiNib     = txHiNib;
    next_txLastPend  = txLastPend;
    next_txPins      = txPins;
    if (txTick) begin
      case (mode)
        MODE_TBI: begin
          // whole group at once, bit 9 on the enable pin, bit 8 on its own
          next_txPins = '{en: txHold[9], b8: txHold[8], er: 1'b0,
                          data: txHoldValid ? txHold[7:0] : 8'h00};
          if (!txHoldValid) begin
            next_txPins.en = 1'b0;
            next_txPins.b8 = 1'b0;
          end
          next_txHoldValid = 1'b0;
          next_txActive    = txHoldValid;
        end
        MODE_MII: begin
          if (nibbleHi) begin
            next_txPins   = '{en: 1'b1, b8: 1'b0, er: txPins.er, data: {4'h0, txHiNib}};
            next_nibbleHi = 1'b0;
            next_txActive = ~txLastPend;
          end else if (txHoldValid) begin
            next_txPins      = '{en: 1'b1, b8: 1'b0, er: txHold[TXW_ERR],
                                 data: {4'h0, txHold[3:0]}};
            next_txHiNib     = txHold[7:4];
            next_txLastPend  = txHold[TXW_LAST];
            next_nibbleHi    = 1'b1;
            next_txHoldValid = 1'b0;
            next_txActive    = 1'b1;
          end else begin
            next_txPins   = '0;
            next_txActive = 1'b0;
          end
        end
        default: begin
          // an empty holding register ends the frame rather than stall it
          if (txHoldValid) begin
            next_txPins      = '{en: 1'b1, b8: 1'b0, er: txHold[TXW_ERR], data: txHold[7:0]};
            next_txHoldValid = 1'b0;
            next_txActive    = ~txHold[TXW_LAST];
          end else begin
            next_txPins   = '0;
            next_txActive = 1'b0;
          end
        end
      endcase
    end
    if (wrTx & ~next_txHoldValid) begin
      next_txHold      = pwdata[11:0];
      next_txHoldValid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gtxCnt      <= 4'h0;
      gtxClk      <= 1'b0;
      txHold      <= 12'h000;
      txHoldValid <= 1'b0;
      txActive    <= 1'b0;
      nibbleHi    <= 1'b0;
      txHiNib     <= 4'h0;
      txLastPend  <= 1'b0;
      txPins      <= '0;
    end else begin
      gtxCnt      <= next_gtxCnt;
      gtxClk      <= next_gtxClk;
      txHold      <= next_txHold;
      txHoldValid <= next_txHoldValid;
      txActive    <= next_txActive;
      nibbleHi    <= next_nibbleHi;
      txHiNib     <= next_txHiNib;
      txLastPend  <= next_txLastPend;
      txPins      <= next_txPins;
    end
  end

  // receive: sample at clock rises, assemble, flag errors and overrun
  always_comb begin
    next_rxLow     = rxLow;
    next_rxHalf    = rxHalf;
    next_rxInFrame = rxInFrame;
    pushRx         = 1'b0;
    pushWord       = 12'h000;
    if (mode == MODE_TBI) begin
      // the bundle is a group with bit 0 first on the wire and bit 9 last
      if (oddRise) begin
        pushRx   = 1'b1;
        pushWord = {1'b1, 1'b0, rxPrev.er, rxPrev.dv, rxPrev.data};
      end else if (evenRise) begin
        pushRx   = 1'b1;
        pushWord = {1'b0, 1'b0, rxPrev.er, rxPrev.dv, rxPrev.data};
      end
      next_rxInFrame = 1'b0;
    end else if (oddRise) begin
      next_rxInFrame = rxPrev.dv;
      if (rxPrev.dv) begin
        if (mode == MODE_MII) begin
          next_rxHalf = ~rxHalf;
          next_rxLow  = rxPrev.data[3:0];
          if (rxHalf) begin
            pushRx   = 1'b1;
            pushWord = {4'h0, rxPrev.data[3:0], rxLow};
          end
        end else begin
          pushRx   = 1'b1;
          pushWord = {4'h0, rxPrev.data};
        end
      end else begin
        next_rxHalf = 1'b0;
        if (rxInFrame) begin
          pushRx   = 1'b1;
          pushWord = 12'h000 | (12'h001 << RXW_END);  // end-of-frame marker word
        end
      end
    end
    next_rxWord  = pushRx ? pushWord : rxWord;
    next_rxValid = pushRx | (rxValid & ~rdRx);  // new word beats the read
    // sticky flags: a setting event wins over a clear in the same cycle
    next_codeErr = (mode != MODE_TBI & oddRise & rxPrev.dv & rxPrev.er)
                 | (codeErr & ~(wrClr & pwdata[ST_CODE_ERR]));
    next_overrun = (pushRx & rxValid & ~rdRx) | (overrun & ~(wrClr & pwdata[ST_OVERRUN]));
    next_colSeen = colEff | (colSeen & ~(wrClr & pwdata[ST_COL_SEEN]));
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxWord    <= 12'h000;
      rxValid   <= 1'b0;
      rxLow     <= 4'h0;
      rxHalf    <= 1'b0;
      rxInFrame <= 1'b0;
      codeErr   <= 1'b0;
      overrun   <= 1'b0;
      colSeen   <= 1'b0;
    end else begin
      rxWord    <= next_rxWord;
      rxValid   <= next_rxValid;
      rxLow     <= next_rxLow;
      rxHalf    <= next_rxHalf;
      rxInFrame <= next_rxInFrame;
      codeErr   <= next_codeErr;
      overrun   <= next_overrun;
      colSeen   <= next_colSeen;
    end
  end

  // lamps follow software link state and live traffic
  link_indicator u_lamps (
    .ref_clk        (ref_clk),
    .arst_n         (arst_n),
    .tbiMode        (mode == MODE_TBI),
    .selectCode     (ctrl[CTRL_LED_LSB +: 2]),
    .powerDown      (ctrl[CTRL_PWR_DOWN]),
    .linkUp         (ctrl[CTRL_LINK_UP]),
    .speed          (ctrl[CTRL_SPD_LSB +: 2]),
    .fullDuplex     (fullDuplex),
    .txAct          (txActive),
    .rxAct          (rxInFrame),
    .linkIndicatorN (linkIndicatorN)
  );

endmodule

// >>> verif/phy_media_props.sv
// checker for the media interface: tx timing, lamps, status masking
// assumes it is bound to phy_media_interface and sees only its ports
`timescale 1ns/10ps
module phy_media_props
  import phy_media_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        txClkIn,
  input wire logic        gtxClk,
  input wire tx_pins_s    txPins,
  input wire logic [3:0]  linkIndicatorN,
  input wire logic        tenbitLoopbackFlagOut
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [9:0] ctrl;
  logic [9:0] next_ctrl;
  logic       prevTx;
  logic [3:0] sinceTx;
  logic [3:0] next_sinceTx;
  logic       isMii;
  logic       isTbi;
  logic       stRd;
  logic       loopWant;
  logic       pwrDn;
  // shadow control taken from committed writes; age of last tx clock rise
  always_comb begin
    next_ctrl = ctrl;
    if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) next_ctrl = pwdata[9:0];
    next_sinceTx = (sinceTx == 4'hf) ? sinceTx : sinceTx + 4'h1;
    if (txClkIn && !prevTx) next_sinceTx = 4'h0;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl    <= CTRL_RESET;
      prevTx  <= 1'b0;
      sinceTx <= 4'hf; // saturated so a stray change cannot pass
    end else begin
      ctrl    <= next_ctrl;
      prevTx  <= txClkIn;
      sinceTx <= next_sinceTx;
    end
  end
  // decoded views of the shadow
  assign isMii = ctrl[1:0] == MODE_MII;
  assign isTbi = ctrl[1:0] == MODE_TBI;
  assign loopWant = isTbi && ctrl[CTRL_LOOPBACK];
  assign pwrDn = ctrl[CTRL_PWR_DOWN];
  assign stRd = psel && penable && pready && !pwrite && paddr == ADDR_STATUS;

  property p_gtxRun;
    $past(arst_n) |-> gtxClk != $past(gtxClk);
  endproperty
  a_gtxRun: assert property (p_gtxRun) else $error("gtx clock stalled");
  property p_txFast;
    !isMii && !$past(isMii) && $changed(txPins) |-> $fell(gtxClk);
  endproperty
  a_txFast: assert property (p_txFast) else $error("tx pins off gtx fall");
  property p_txMii;
    isMii && $past(isMii) && $changed(txPins) |-> sinceTx inside {[4'h2:4'h5]};
  endproperty
  a_txMii: assert property (p_txMii) else $error("tx pins off tx clock");
  property p_miiNibble;
    isMii && $past(isMii) && $changed(txPins) |-> txPins.data[7:4] == 4'h0;
  endproperty
  a_miiNibble: assert property (p_miiNibble) else $error("upper tx lines used");
  property p_colFull;
    stRd && ctrl[CTRL_FULL_DUP] |-> prdata[ST_COL_NOW] == 1'b0;
  endproperty
  a_colFull: assert property (p_colFull) else $error("collision in full duplex");
  property p_tbiIgnore;
    stRd && isTbi |-> prdata[ST_COL_NOW] == 1'b0 && prdata[ST_CRS] == 1'b0;
  endproperty
  a_tbiIgnore: assert property (p_tbiIgnore) else $error("col or crs in tbi");
  property p_loopFlag;
    $past(arst_n) |-> tenbitLoopbackFlagOut == $past(loopWant);
  endproperty
  a_loopFlag: assert property (p_loopFlag) else $error("loopback flag wrong");
  property p_lampOff;
    pwrDn && $past(pwrDn) |-> linkIndicatorN == 4'hf;
  endproperty
  a_lampOff: assert property (p_lampOff) else $error("lamp lit in power down");
  c_miiTx: cover property (isMii && $changed(txPins));
  c_tbiRd: cover property (stRd && isTbi);
  c_loop: cover property ($rose(tenbitLoopbackFlagOut));
endmodule
bind phy_media_interface phy_media_props u_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .txClkIn(txClkIn),
  .gtxClk(gtxClk), .txPins(txPins), .linkIndicatorN(linkIndicatorN),
  .tenbitLoopbackFlagOut(tenbitLoopbackFlagOut)
);

// >>> verif/phy_model.sv
// far-side transceiver: tx clock, two receive clocks, receive pins
// assumes the bench calls sendRx; clocks run free as the link demands
`timescale 1ns/10ps
module phy_model
  import phy_media_pkg::*;
(
  output logic     txClk,
  output logic     oddClk,
  output logic     evenClk,
  output rx_pins_s rxPins
);
  // continuous 800 ns tx clock, phase unrelated to ref_clk
  initial begin
    txClk = 1'b0;
    #130;
    forever #400 txClk = ~txClk;
  end
  // receive clocks half a period apart, so groups alternate
  initial begin
    oddClk = 1'b0;
    evenClk = 1'b1;
    rxPins = '0;
    #270;
    forever begin
      #400;
      oddClk = ~oddClk;
      evenClk = ~evenClk;
    end
  end
  // pins change 100 ns after the other clock rises, stable around own rise
  task automatic sendRx(input logic odd, input rx_pins_s p);
    if (odd) @(posedge evenClk);
    else @(posedge oddClk);
    #100;
    rxPins = p;
    if (odd) @(posedge oddClk);
    else @(posedge evenClk);
  endtask
endmodule

// >>> verif/phy_media_interface_tb_top.sv
// self-checking bench for the media interface block
// assumes phy_model stands in for the transceiver; 10 MHz ref_clk
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module phy_media_interface_tb_top
  import phy_media_pkg::*;
;
  logic        ref_clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        txClk;
  logic        oddClk;
  logic        evenClk;
  rx_pins_s    rxPins;
  logic        collisionIn;
  logic        carrierSenseIn;
  logic        gtxClk;
  tx_pins_s    txPins;
  logic [3:0]  linkIndicatorN;
  logic        loopFlag;
  logic [31:0] rdata;
  logic        rerr;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  phy_media_interface DUT (
    .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txClkIn(txClk), .oddGroupRxClock(oddClk), .evenGroupRxClock(evenClk), .rxPins(rxPins),
    .collisionIn(collisionIn), .carrierSenseIn(carrierSenseIn), .gtxClk(gtxClk), .txPins(txPins),
    .linkIndicatorN(linkIndicatorN), .tenbitLoopbackFlagOut(loopFlag)
  );
  phy_model phy (.txClk(txClk), .oddClk(oddClk), .evenClk(evenClk), .rxPins(rxPins));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // hang guard: run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one APB transfer; waits for pready as long as it takes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // wait for tx enable, or for any change of the tx pins
  task automatic waitTx(input logic chg);
    tx_pins_s old = txPins;
    int n = 0;
    while ((chg ? txPins === old : txPins.en !== 1'b1) && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  // let the receive word land first
  task automatic rdRx(input logic [7:0] a = ADDR_RXDATA);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic t_regs();
    apb(1'b1, ADDR_CTRL, 32'h1a6);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rdata, 32'h1a6)
    apb(1'b0, 8'h14, 32'h0);
    `CHK({rerr, rdata}, 33'h100000000)
  endtask
  // every select code at gigabit link, full duplex, idle; then power down
  task automatic t_lamps();
    logic [3:0] exp [4] = '{4'h7, 4'h9, 4'h5, 4'h3};
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ADDR_CTRL, 32'h284 | (s << 5));
      repeat (3) @(posedge ref_clk);
      `CHK(linkIndicatorN, exp[s])
    end
    apb(1'b1, ADDR_CTRL, 32'h294);
    repeat (3) @(posedge ref_clk);
    `CHK(linkIndicatorN, 4'hf)
  endtask
  task automatic t_tx();
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_TXDATA, 32'hc5a);
    waitTx(1'b0);
    `CHK(txPins, 11'h55a)
    repeat (2) @(posedge ref_clk);
    `CHK(txPins.en, 1'b0)
    // mii: low nibble first, upper lines idle
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_TXDATA, 32'h496);
    waitTx(1'b0);
    `CHK(txPins, 11'h406)
    waitTx(1'b1);
    `CHK(txPins, 11'h409)
    waitTx(1'b1);
    `CHK(txPins.en, 1'b0)
    // tbi: group spread over enable, bit 8 and data lines
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b1, ADDR_TXDATA, 32'h3b5);
    waitTx(1'b0);
    `CHK(txPins, 11'h6b5)
    repeat (2) @(posedge ref_clk);
    `CHK(txPins, 11'h000)
    apb(1'b1, ADDR_CTRL, 32'ha);
    repeat (2) @(posedge ref_clk);
    `CHK(loopFlag, 1'b1)
    apb(1'b1, ADDR_CTRL, 32'h8);
    repeat (2) @(posedge ref_clk);
    `CHK(loopFlag, 1'b0)
  endtask
  task automatic t_rx();
    apb(1'b1, ADDR_CTRL, 32'h0);
    phy.sendRx(1'b1, 10'h1c3);
    rdRx();
    `CHK(rdata[11:0], 12'h0c3)
    phy.sendRx(1'b1, 10'h311);
    phy.sendRx(1'b1, 10'h0ee);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rdata[ST_CODE_ERR], 1'b1)
    apb(1'b0, ADDR_RXDATA, 32'h0);
    phy.sendRx(1'b1, 10'h011);
    rdRx(ADDR_STATUS);
    `CHK(rdata[ST_RX_VALID], 1'b0)
    // mii nibbles, upper lines carry junk
    apb(1'b1, ADDR_CTRL, 32'h1);
    phy.sendRx(1'b1, 10'h1f5);
    phy.sendRx(1'b1, 10'h1fa);
    rdRx();
    `CHK(rdata[7:0], 8'ha5)
    phy.sendRx(1'b1, 10'h005);
    // tbi odd then even group
    apb(1'b1, ADDR_CTRL, 32'h2);
    phy.sendRx(1'b1, 10'h155);
    rdRx();
    `CHK(rdata[11:0], 12'h955)
    phy.sendRx(1'b0, 10'h2aa);
    rdRx();
    `CHK(rdata[11:0], 12'h2aa)
  endtask
  // collision and carrier held high across half, full duplex and tbi
  task automatic t_col();
    logic [31:0] cfg [3] = '{32'h0, 32'h4, 32'h2};
    logic [1:0]  exp [3] = '{2'h3, 2'h1, 2'h0};
    collisionIn    <= 1'b1;
    carrierSenseIn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_CTRL, cfg[i]);
      repeat (4) @(posedge ref_clk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK({rdata[ST_COL_NOW], rdata[ST_CRS]}, exp[i])
    end
  endtask

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    collisionIn = 1'b0;
    carrierSenseIn = 1'b0;
    repeat (10) @(posedge ref_clk);
    `CHK({linkIndicatorN, loopFlag, txPins}, 16'hf000)
    arst_n <= 1'b1;
    t_regs();
    t_lamps();
    t_tx();
    t_rx();
    t_col();
    conclude();
  end
endmodule
